/* rtl/supply_low_detector.sv */
// Purpose: control logic of the on-chip supply low detector
// Assumes: comparator and reference are analog, outside this block
// Notes: clk keeps running in stop mode so detection carries on

`timescale 1ns/100ps

module supply_low_detector
  import supply_low_detector_pkg::*;
#(
  parameter int NUM_LEVELS = supply_low_detector_pkg::LEVELS_EXPANDED,
  parameter supply_low_detector_pkg::poc_option_e POC_OPTION =
    supply_low_detector_pkg::POC_NONE
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic other_reset,
  input wire logic poc_reset,
  input wire logic [15:0] addr,
  input wire logic byte_wr,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic stop_mode,
  input wire logic comparator_below,
  output logic comparator_enable,
  output logic ref_gen_on,
  output logic [2:0] detect_threshold,
  output logic supply_low_irq,
  output logic detector_reset,
  output logic detector_reset_cause_flag
);
  import supply_low_detector_pkg::*;

  // ==========================================================
  // state
  logic detect_enable_r;
  logic ref_gen_enable_r;
  logic reset_mode_select_r;
  logic [LEVEL_W-1:0] level_r;
  logic irq_r;
  logic det_rst_r;
  logic cause_r;
  logic [7:0] rd_data_r;
  logic below_sync;

  // stop mode deliberately gates nothing here
  logic stop_unused;
  assign stop_unused = stop_mode;

  // ==========================================================
  // comparator output crosses into clk domain
  level_sync u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(comparator_below),
    .sync_out(below_sync)
  );

  // ==========================================================
  // address decode and write strobes
  logic hit_ctrl;
  logic hit_level;
  logic ctrl_byte_wr;
  logic ctrl_bit_wr;
  logic level_byte_wr;
  assign hit_ctrl = (addr == CTRL_ADDR);
  assign hit_level = (addr == LEVEL_ADDR);
  assign ctrl_byte_wr = hit_ctrl & byte_wr;
  assign ctrl_bit_wr = hit_ctrl & bit_wr & ~byte_wr;
  // bit writes to the level register are ignored
  assign level_byte_wr = hit_level & byte_wr;

  // picks the new value of one control bit for either write width
  function automatic logic ctrl_bit_next(input logic cur, input int pos,
                                         input logic bw, input logic bb,
                                         input logic [2:0] sel,
                                         input logic v,
                                         input logic [7:0] d);
    logic r;
    r = cur;
    if (bw) begin
      r = d[pos];
    end else if (bb && (sel == 3'(pos))) begin
      r = v;
    end
    return r;
  endfunction

  // ==========================================================
  // next values of the writable control bits
  logic detect_enable_nxt;
  logic ref_gen_enable_nxt;
  logic reset_mode_select_nxt;
  logic soft_clear;
  assign detect_enable_nxt = ctrl_bit_next(detect_enable_r,
    DETECT_EN_BIT, ctrl_byte_wr, ctrl_bit_wr, bit_sel, bit_val,
    wr_data);
  assign ref_gen_enable_nxt = ctrl_bit_next(ref_gen_enable_r,
    REF_EN_BIT, ctrl_byte_wr, ctrl_bit_wr, bit_sel, bit_val,
    wr_data);
  assign reset_mode_select_nxt = ctrl_bit_next(reset_mode_select_r,
    MODE_BIT, ctrl_byte_wr, ctrl_bit_wr, bit_sel, bit_val,
    wr_data);
  // any reset but our own clears the control bits
  assign soft_clear = other_reset | poc_reset;

  // control bits; the detector's own reset is not a clear term
  always_ff @(posedge clk) begin
    if (reset || soft_clear) begin
      detect_enable_r <= CTRL_RESET[DETECT_EN_BIT];
      ref_gen_enable_r <= CTRL_RESET[REF_EN_BIT];
      reset_mode_select_r <= CTRL_RESET[MODE_BIT];
    end else begin
      detect_enable_r <= detect_enable_nxt;
      ref_gen_enable_r <= ref_gen_enable_nxt;
      reset_mode_select_r <= reset_mode_select_nxt;
    end
  end

  // ==========================================================
  // level select: only the external reset clears it
  logic [LEVEL_W-1:0] level_nxt;
  assign level_nxt = level_byte_wr ? wr_data[LEVEL_W-1:0] : level_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      level_r <= LEVEL_RESET;
    end else begin
      level_r <= level_nxt;
    end
  end

  // ==========================================================
  // usable levels per grade; codes past the last one clamp to it
  localparam logic [2:0] LAST_CODE = 3'(NUM_LEVELS - 1);
  assign detect_threshold = (level_r > LAST_CODE) ? LAST_CODE
                                                  : level_r;

  // codes that sit at or below the power-on-clear threshold
  logic poc_shadowed;
  assign poc_shadowed =
    ((POC_OPTION == POC_350) && (level_r >= POC_350_MIN_CODE)) ||
    ((POC_OPTION == POC_285) && (level_r >= POC_285_MIN_CODE));

  // ==========================================================
  // analog enables
  assign comparator_enable = detect_enable_r;
  // with power-on-clear fitted the reference never stops
  assign ref_gen_on = (POC_OPTION != POC_NONE) | ref_gen_enable_r;

  // ==========================================================
  // flag is zero whenever detection is off
  logic below_level_flag;
  assign below_level_flag = below_sync & detect_enable_r;

  // request next values; power-on-clear wins over our reset
  logic irq_nxt;
  logic det_rst_nxt;
  assign irq_nxt = below_level_flag & ~reset_mode_select_r;
  assign det_rst_nxt = below_level_flag & reset_mode_select_r
                       & ~poc_reset;

  // request outputs run regardless of stop mode
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r <= 1'b0;
      det_rst_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      det_rst_r <= det_rst_nxt;
    end
  end

  assign supply_low_irq = irq_r;
  assign detector_reset = det_rst_r;

  // ==========================================================
  // reset cause: set beats clear, power-on-clear zeroes it
  logic cause_nxt;
  assign cause_nxt = det_rst_r ? 1'b1 : (poc_reset ? 1'b0 : cause_r);

  always_ff @(posedge clk) begin
    if (reset) begin
      cause_r <= 1'b0;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  assign detector_reset_cause_flag = cause_r;

  // ==========================================================
  // read path; unused bits and other addresses read zero
  logic [7:0] ctrl_view;
  logic [7:0] level_view;
  logic [7:0] rd_nxt;
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[DETECT_EN_BIT] = detect_enable_r;
    ctrl_view[REF_EN_BIT] = ref_gen_enable_r;
    ctrl_view[MODE_BIT] = reset_mode_select_r;
    ctrl_view[FLAG_BIT] = below_level_flag;
    level_view = 8'h00;
    level_view[LEVEL_W-1:0] = level_r;
  end
  assign rd_nxt = !rd_en ? rd_data_r :
                  hit_ctrl ? ctrl_view :
                  hit_level ? level_view : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_nxt;
    end
  end

  assign rd_data = rd_data_r;

  // ==========================================================
  // checks
  sequence s_byte_zero_ctrl;
    !reset && !soft_clear && ctrl_byte_wr && (wr_data == 8'h00);
  endsequence

  sequence s_below_irq_mode;
    detect_enable_r && !reset_mode_select_r && below_sync;
  endsequence

  a_irq_gate: assert property (@(posedge clk) disable iff (reset)
    supply_low_irq |-> $past(detect_enable_r)
      && !$past(reset_mode_select_r) && $past(below_sync))
    else $error("irq raised without enable, mode and flag");

  a_irq_follow: assert property (@(posedge clk) disable iff (reset)
    s_below_irq_mode |=> supply_low_irq)
    else $error("irq missed a below-level condition");

  a_reset_gate: assert property (@(posedge clk) disable iff (reset)
    detector_reset |-> $past(reset_mode_select_r)
      && $past(below_level_flag) && !$past(poc_reset))
    else $error("detector reset without cause");

  a_flag_off: assert property (@(posedge clk) disable iff (reset)
    !detect_enable_r |-> !below_level_flag)
    else $error("flag set while detection disabled");

  a_cause_set: assert property (@(posedge clk) disable iff (reset)
    detector_reset |=> detector_reset_cause_flag)
    else $error("cause flag not set by detector reset");

  a_ctrl_survive: assert property (@(posedge clk) disable iff (reset)
    (detector_reset && !soft_clear && !ctrl_byte_wr && !ctrl_bit_wr)
      |=> $stable(reset_mode_select_r) && $stable(detect_enable_r))
    else $error("control bits lost on detector reset");

  a_other_clear: assert property (@(posedge clk) disable iff (reset)
    soft_clear |=> !detect_enable_r && !ref_gen_enable_r
      && !reset_mode_select_r)
    else $error("control bits kept over another reset");

  a_byte_stop: assert property (@(posedge clk) disable iff (reset)
    s_byte_zero_ctrl |=> !comparator_enable ##1 !supply_low_irq)
    else $error("byte write of zero did not stop detection");

  a_level_bitwr: assert property (@(posedge clk) disable iff (reset)
    (hit_level && bit_wr && !byte_wr) |=> $stable(level_r))
    else $error("bit write changed the level register");

  a_ref_poc: assert property (@(posedge clk) disable iff (reset)
    (POC_OPTION != POC_NONE) |-> ref_gen_on)
    else $error("reference stopped with power-on-clear fitted");

  a_sync_lag: assert property (@(posedge clk) disable iff (reset)
    $rose(below_sync) |-> $past(comparator_below, 2))
    else $error("synchroniser shorter than two stages");

  // reset mode with no power-on-clear pending must request our reset
  sequence s_below_reset_mode;
    detect_enable_r && reset_mode_select_r && below_sync && !poc_reset;
  endsequence

  a_reset_follow: assert property (@(posedge clk) disable iff (reset)
    s_below_reset_mode |=> detector_reset)
    else $error("detector reset missed a below-level condition");

  // stop mode must not silence the interrupt path
  a_stop_irq: assert property (@(posedge clk) disable iff (reset)
    stop_unused ##0 s_below_irq_mode |=> supply_low_irq)
    else $error("interrupt lost in stop mode");

  // shadowed codes: power-on-clear has the last word
  a_poc_first: assert property (@(posedge clk) disable iff (reset)
    (poc_shadowed && poc_reset) |=> !detector_reset)
    else $error("detector reset beat power-on-clear");

  a_level_write: assert property (@(posedge clk) disable iff (reset)
    level_byte_wr |=> (level_r == $past(wr_data[LEVEL_W-1:0])))
    else $error("level byte write did not land");

  // flag in read data must be the flag of the read cycle
  a_flag_read: assert property (@(posedge clk) disable iff (reset)
    (rd_en && hit_ctrl) |=> (rd_data[FLAG_BIT] == $past(below_level_flag)))
    else $error("read data flag does not match flag");

  a_ref_write: assert property (@(posedge clk) disable iff (reset)
    (ctrl_byte_wr && !soft_clear)
      |=> (ref_gen_enable_r == $past(wr_data[REF_EN_BIT])))
    else $error("reference enable missed a byte write");

  // analog side never sees a code past the grade's last level
  a_thr_clamp: assert property (@(posedge clk) disable iff (reset)
    detect_threshold <= LAST_CODE)
    else $error("threshold code beyond usable levels");

endmodule

/* rtl/supply_low_detector_pkg.sv */
// Purpose: shared constants for the supply low detector control block
// Assumes: 8-bit register port of the processor core, 16-bit addresses
// Notes: level codes 0..7 map to falling thresholds, 0 the highest

package supply_low_detector_pkg;

  // ==========================================================
  // register addresses
  localparam logic [15:0] CTRL_ADDR = 16'hffbe;
  localparam logic [15:0] LEVEL_ADDR = 16'hffbf;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] LEVEL_RESET = 3'h0;

  // ==========================================================
  // control/status field positions
  localparam int DETECT_EN_BIT = 7;
  localparam int REF_EN_BIT = 4;
  localparam int MODE_BIT = 1;
  localparam int FLAG_BIT = 0;

  // level select field width; the bits above read as zero
  localparam int LEVEL_W = 3;

  // reset cause register: position of the detector cause flag
  localparam int CAUSE_BIT = 0;

  // ==========================================================
  // power-on-clear option and its lowest forbidden level codes
  typedef enum logic [1:0] {
    POC_NONE = 2'b00,
    POC_285 = 2'b01,
    POC_350 = 2'b10
  } poc_option_e;

  localparam logic [2:0] POC_350_MIN_CODE = 3'h4;
  localparam logic [2:0] POC_285_MIN_CODE = 3'h7;

  // detection levels by product grade
  localparam int LEVELS_EXPANDED = 8;
  localparam int LEVELS_CONVENTIONAL = 7;
  localparam int LEVELS_HIGH_TEMP = 5;

  // software waits, kept for reference by drivers (microseconds)
  localparam real DETECT_SETTLE_US = 200.0;
  localparam real REF_SETTLE_US = 2000.0;
  localparam real CLK_PERIOD_NS = 4.0;
  localparam int DETECT_SETTLE_CYC =
    int'($ceil(DETECT_SETTLE_US * 1000.0 / CLK_PERIOD_NS));
  localparam int REF_SETTLE_CYC =
    int'($ceil(REF_SETTLE_US * 1000.0 / CLK_PERIOD_NS));

endpackage

/* rtl/level_sync.sv */
// Purpose: two flip-flop synchroniser for one asynchronous level
// Assumes: input may change at any time relative to clk
// Notes: first stage is read only by the second stage

`timescale 1ns/100ps

module level_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;
  logic sync_r;

  // ==========================================================
  // two stages; metastability settles in the first
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

/* sim/core_model.sv */
// Purpose: processor core side of the detector register port
// Assumes: strobes launched at the falling edge, one access per call
// Notes: released address and data lines show the inverse of last value

`timescale 1ns/100ps

module core_model (
  input wire logic clk,
  output logic [15:0] addr,
  output logic byte_wr,
  output logic bit_wr,
  output logic [2:0] bit_sel,
  output logic bit_val,
  output logic [7:0] wr_data,
  output logic rd_en,
  input wire logic [7:0] rd_data
);
  // ==========================================================
  // idle bus from time zero
  initial begin
    addr = 16'h0000;
    byte_wr = 1'b0;
    bit_wr = 1'b0;
    bit_sel = 3'h0;
    bit_val = 1'b0;
    wr_data = 8'h00;
    rd_en = 1'b0;
  end

  // kind 0 byte write, 1 bit write, 2 read; one rising edge per access
  task automatic access(input logic [15:0] a, input logic [7:0] d,
      input logic [2:0] s, input logic [1:0] kind, output logic [7:0] q);
    @(negedge clk);
    addr = a;
    wr_data = d;
    bit_sel = s;
    bit_val = d[0];
    byte_wr = (kind == 2'h0);
    bit_wr = (kind == 2'h1);
    rd_en = (kind == 2'h2);
    @(negedge clk);
    q = rd_data;
    byte_wr = 1'b0;
    bit_wr = 1'b0;
    rd_en = 1'b0;
    // stale values would hide a decode that ignores the strobe
    addr = ~a;
    wr_data = ~d;
  endtask
endmodule

/* sim/supply_low_detector_tb.sv */
// Purpose: self-checking bench of the supply low detector control
// Assumes: default parameters, eight levels, no power-on-clear fitted
// Notes: analog settle waits are not modelled, the block ignores them

`timescale 1ns/100ps

module supply_low_detector_tb;
  import supply_low_detector_pkg::*;
  logic clk = 1'b0, reset, other_reset, poc_reset, stop_mode, below;
  logic [15:0] addr;
  logic byte_wr, bit_wr, bit_val, rd_en, en, ref_on, irq, det_rst, cause;
  logic [2:0] bit_sel, thr;
  logic [7:0] wr_data, rd_data, d;
  int error_cnt = 0, check_count = 0, seed, i;

  // ==========================================================
  // clock and instances
  always #2 clk = ~clk;

  supply_low_detector supply_low_detector_inst (.clk(clk), .reset(reset),
    .other_reset(other_reset), .poc_reset(poc_reset), .addr(addr),
    .byte_wr(byte_wr), .bit_wr(bit_wr), .bit_sel(bit_sel),
    .bit_val(bit_val), .wr_data(wr_data), .rd_en(rd_en),
    .rd_data(rd_data), .stop_mode(stop_mode), .comparator_below(below),
    .comparator_enable(en), .ref_gen_on(ref_on), .detect_threshold(thr),
    .supply_low_irq(irq), .detector_reset(det_rst),
    .detector_reset_cause_flag(cause));

  core_model core_model_inst (.clk(clk), .addr(addr), .byte_wr(byte_wr),
    .bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data));

  // ==========================================================
  // helpers
  function automatic logic [7:0] exp_ctrl(logic [7:0] v, logic b);
    return (v & 8'h92) | {7'h00, v[7] & b};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    logic [7:0] q;
    core_model_inst.access(a, v, 3'h0, 2'h0, q);
  endtask

  task automatic bitwr(input logic [15:0] a, input logic [2:0] s,
      input logic v);
    logic [7:0] q;
    core_model_inst.access(a, {7'h00, v}, s, 2'h1, q);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    core_model_inst.access(a, 8'h00, 3'h0, 2'h2, q);
    check(q, e);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    cyc(5000);
    error_cnt++;
    tally_and_finish;
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 8;
    reset = 1'b1;
    other_reset = 1'b0;
    poc_reset = 1'b0;
    stop_mode = 1'b0;
    below = 1'b0;
    cyc(16);
    reset = 1'b0;
    rdchk(CTRL_ADDR, 8'h00);
    rdchk(LEVEL_ADDR, 8'h00);
    rdchk(16'hffbd, 8'h00);
    // random control bytes; flag and unused bits must read zero
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(CTRL_ADDR, d);
      chk1(en, d[7]);
      chk1(ref_on, d[4]);
      rdchk(CTRL_ADDR, exp_ctrl(d, 1'b0));
    end
    // random level codes, upper bits kept zero by software
    for (i = 0; i < 8; i++) begin
      d = $random(seed) & 8'h07;
      wr(LEVEL_ADDR, d);
      check({5'h00, thr}, d);
      rdchk(LEVEL_ADDR, d);
    end
    wr(LEVEL_ADDR, 8'h07);
    bitwr(LEVEL_ADDR, 3'h0, 1'b0);
    rdchk(LEVEL_ADDR, 8'h07);
    check({5'h00, thr}, 8'h07);
    // bit writes build interrupt mode; flag bit refuses writes
    wr(CTRL_ADDR, 8'h00);
    bitwr(CTRL_ADDR, 3'h4, 1'b1);
    cyc(2);
    bitwr(CTRL_ADDR, 3'h7, 1'b1);
    cyc(2);
    bitwr(CTRL_ADDR, 3'h0, 1'b1);
    rdchk(CTRL_ADDR, 8'h90);
    stop_mode = 1'b1;
    below = 1'b1;
    cyc(4);
    chk1(irq, 1'b1);
    chk1(det_rst, 1'b0);
    rdchk(CTRL_ADDR, 8'h91);
    // switch to reset mode while the supply is low
    bitwr(CTRL_ADDR, 3'h1, 1'b1);
    cyc(3);
    chk1(det_rst, 1'b1);
    chk1(irq, 1'b0);
    chk1(cause, 1'b1);
    rdchk(CTRL_ADDR, 8'h93);
    below = 1'b0;
    cyc(4);
    chk1(det_rst, 1'b0);
    other_reset = 1'b1;
    cyc(1);
    other_reset = 1'b0;
    rdchk(CTRL_ADDR, 8'h00);
    chk1(cause, 1'b1);
    // disabled detection hides a low supply
    below = 1'b1;
    cyc(4);
    rdchk(CTRL_ADDR, 8'h00);
    chk1(irq, 1'b0);
    poc_reset = 1'b1;
    cyc(1);
    poc_reset = 1'b0;
    chk1(cause, 1'b0);
    // stop by bit clears in order, then an external reset
    below = 1'b0;
    wr(CTRL_ADDR, 8'h90);
    bitwr(CTRL_ADDR, 3'h7, 1'b0);
    bitwr(CTRL_ADDR, 3'h4, 1'b0);
    chk1(ref_on, 1'b0);
    rdchk(CTRL_ADDR, 8'h00);
    reset = 1'b1;
    cyc(1);
    reset = 1'b0;
    rdchk(LEVEL_ADDR, 8'h00);
    tally_and_finish;
  end
endmodule
